// file: src/ufc_defs.svh
// constants for the serial receive block with frame check and address match
// assumes inclusion by bare name from design files
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

`define UFC_CLK_HZ       25000000
`define UFC_DIV_W        16
`define UFC_DIV_M2_FAST  16'h0020
`define UFC_DIV_M2_SLOW  16'h0040
`define UFC_CNT_W        4
`define UFC_OVS          4'hf
`define UFC_OVS_MID      4'h7
`define UFC_BITS_8       4'h8
`define UFC_BITS_9       4'h9
`define UFC_ADDR_RST     8'h00
`define UFC_MASK_RST     8'h00
`define UFC_BUF_DEPTH    2

`endif

// file: src/ufc_pkg.sv
// types shared by the serial receive block modules
// assumes ufc_defs.svh sits on the include path
package ufc_pkg;
    typedef enum logic [1:0] {
        UFC_MODE_SHIFT,
        UFC_MODE_UART8,
        UFC_MODE_UART9F,
        UFC_MODE_UART9V
    } ufc_mode_e;

    typedef enum logic [2:0] {
        UFC_ST_IDLE,
        UFC_ST_START,
        UFC_ST_DATA,
        UFC_ST_STOP,
        UFC_ST_DONE
    } ufc_state_e;

    typedef logic [7:0] ufc_byte_t;
endpackage

// file: src/ufc_stream_if.sv
// valid/ready word carrier between the receiver and its buffer
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface ufc_stream_if;
    logic              valid;
    logic              ready;
    ufc_pkg::ufc_byte_t data;
    logic              ninth;
    modport src (output valid, output data, output ninth, input ready);
    modport snk (input valid, input data, input ninth, output ready);
endinterface

// file: src/ufc_buf2.sv
// two-entry buffer with valid and ready on both sides, output muxed combinationally from the entry at the read pointer
// assumes same clock as the receiver; sink may stall at will
`timescale 1ns/1ps
`include "ufc_defs.svh"
module ufc_buf2 (
    // clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    // fill side
    ufc_stream_if.snk               in_s,
    // drain side
    output logic                    o_valid,
    output ufc_pkg::ufc_byte_t      o_data,
    output logic                    o_ninth,
    input  wire logic               i_ready
);
    logic [8:0] mem_q [`UFC_BUF_DEPTH];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] cnt_q;
    logic       push;
    logic       pop;
    logic [8:0] head;

    assign in_s.ready = (cnt_q != 2'(`UFC_BUF_DEPTH));
    assign push       = in_s.valid && in_s.ready;
    assign pop        = (cnt_q != 2'h0) && i_ready;
    assign head       = mem_q[rp_q];
    assign o_valid    = (cnt_q != 2'h0);
    assign o_data     = head[7:0];
    assign o_ninth    = head[8];

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wp_q] <= {in_s.ninth, in_s.data};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wp_q  <= wp_q ^ push;
            rp_q  <= rp_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// file: src/ufc_rx.sv
// receive side of a serial port with frame check and address recognition
// assumes baud ticks at 16x rate from outside for modes 1 and 3,
// a reset that is synchronous to i_mclk, and an rx pin from off chip
`timescale 1ns/1ps
`include "ufc_defs.svh"
module ufc_rx (
    // clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    // serial line and baud
    input  wire logic               i_rxd,
    input  wire logic               i_baud_tick,
    input  wire logic               i_fast_m2,
    // control bits
    input  wire logic               i_frame_check_enable,
    input  wire logic               i_serial_mode_bit_hi_wr,
    input  wire logic               i_serial_mode_bit_lo,
    input  wire logic               i_multiproc_enable,
    input  wire logic               i_receive_enable,
    input  wire logic               i_top_bit_wr,
    input  wire logic               i_top_bit_wdata,
    input  wire logic               i_done_clear,
    // address registers
    input  wire logic               i_addr_wr,
    input  wire logic               i_mask_wr,
    input  wire ufc_pkg::ufc_byte_t i_wdata,
    // status
    output logic                    o_top_bit,
    output logic                    o_frame_error_flag,
    output logic                    o_receive_done_flag,
    output logic                    o_received_ninth_bit,
    output ufc_pkg::ufc_byte_t      o_own_address_reg,
    output ufc_pkg::ufc_byte_t      o_address_mask_reg,
    // received data stream
    output logic                    o_rx_valid,
    output ufc_pkg::ufc_byte_t      o_rx_data,
    input  wire logic               i_rx_ready
);
    ufc_pkg::ufc_state_e  st_q;
    ufc_pkg::ufc_mode_e   mode;
    ufc_pkg::ufc_byte_t   sh_q;
    ufc_pkg::ufc_byte_t   addr_q;
    ufc_pkg::ufc_byte_t   mask_q;
    ufc_pkg::ufc_byte_t   bcast;
    logic [`UFC_CNT_W-1:0] ovs_q;
    logic [`UFC_CNT_W-1:0] nbit_q;
    logic [`UFC_DIV_W-1:0] div_q;
    logic [2:0]           sync_q;
    logic                 rxd_q;
    logic                 m0_q;
    logic                 fe_q;
    logic                 ri_q;
    logic                 rb8_q;
    logic                 ninth_q;
    logic                 v_q;
    logic                 tick;
    logic                 m2_tick;
    logic                 sample;
    logic                 async_mode;
    logic                 nine_bit;
    logic                 chk_on;
    logic                 mp_on;
    logic                 given_hit;
    logic                 bcast_hit;
    logic                 addr_hit;
    logic                 stop_ok;
    logic                 accept;
    logic                 last_data;
    logic                 done_at_data;
    logic                 done_at_stop;
    logic                 frame_end;
    logic                 rb8_in;
    logic [`UFC_DIV_W-1:0] div_max;
    logic                 buf_valid;
    logic                 early_q;
    ufc_pkg::ufc_byte_t   buf_data;

    ufc_stream_if rx_s ();

    // pin synchroniser: change taken when second and third stage agree
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync_q <= 3'h7;
            rxd_q  <= 1'b1;
        end else begin
            sync_q <= {sync_q[1:0], i_rxd};
            if (sync_q[1] == sync_q[2]) begin
                rxd_q <= sync_q[2];
            end
        end
    end

    assign mode       = ufc_pkg::ufc_mode_e'({m0_q, i_serial_mode_bit_lo});
    assign async_mode = (mode != ufc_pkg::UFC_MODE_SHIFT);
    assign nine_bit   = mode[1];
    assign chk_on     = i_frame_check_enable && async_mode;
    assign mp_on      = i_multiproc_enable && async_mode;

    // mode 2 fixed rate, other async modes use external tick
    assign div_max = i_fast_m2 ? `UFC_DIV_M2_FAST : `UFC_DIV_M2_SLOW;
    // >= so a rate switch mid-count cannot overrun the divider
    assign m2_tick = (div_q >= div_max);
    assign tick    = (mode == ufc_pkg::UFC_MODE_UART9F) ? m2_tick
                                                        : i_baud_tick;
    assign sample  = tick && (ovs_q == `UFC_OVS);

    always_ff @(posedge i_mclk) begin
        if (i_rst || m2_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign bcast     = addr_q | mask_q;
    assign given_hit = (((sh_q ^ addr_q) & mask_q) == 8'h00);
    assign bcast_hit = (((sh_q ^ bcast) & bcast) == 8'h00);
    assign addr_hit  = given_hit || bcast_hit;

    assign stop_ok   = rxd_q;
    // ninth bit is stop bit in mode 1
    assign rb8_in    = nine_bit ? ninth_q : stop_ok;
    assign accept    = !mp_on || (rb8_in && addr_hit &&
                       (nine_bit || stop_ok));
    assign last_data = (st_q == ufc_pkg::UFC_ST_DATA) && sample &&
                       (nbit_q == (nine_bit ? `UFC_BITS_9 : `UFC_BITS_8)
                        - 1'b1);
    assign done_at_data = last_data && !chk_on && !nine_bit && !mp_on;
    assign done_at_stop = (st_q == ufc_pkg::UFC_ST_STOP) && sample;
    assign frame_end    = done_at_stop;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_q    <= ufc_pkg::UFC_ST_IDLE;
            ovs_q   <= '0;
            nbit_q  <= '0;
            sh_q    <= `UFC_ADDR_RST;
            ninth_q <= 1'b0;
        end else begin
            if (tick) begin
                ovs_q <= ovs_q + 1'b1;
            end
            case (st_q)
                ufc_pkg::UFC_ST_IDLE: begin
                    if (!rxd_q && i_receive_enable && async_mode) begin
                        st_q  <= ufc_pkg::UFC_ST_START;
                        ovs_q <= `UFC_OVS_MID;
                    end
                end
                ufc_pkg::UFC_ST_START: begin
                    if (sample) begin
                        st_q   <= rxd_q ? ufc_pkg::UFC_ST_IDLE
                                        : ufc_pkg::UFC_ST_DATA;
                        nbit_q <= '0;
                    end
                end
                ufc_pkg::UFC_ST_DATA: begin
                    if (sample) begin
                        if (nbit_q < `UFC_BITS_8) begin
                            sh_q <= {rxd_q, sh_q[7:1]};
                        end else begin
                            ninth_q <= rxd_q;
                        end
                        nbit_q <= nbit_q + 1'b1;
                        if (last_data) begin
                            st_q <= ufc_pkg::UFC_ST_STOP;
                        end
                    end
                end
                ufc_pkg::UFC_ST_STOP: begin
                    if (sample) begin
                        st_q <= ufc_pkg::UFC_ST_DONE;
                    end
                end
                default: begin
                    if (rxd_q) begin
                        st_q <= ufc_pkg::UFC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            addr_q <= `UFC_ADDR_RST;
            mask_q <= `UFC_MASK_RST;
        end else begin
            if (i_addr_wr) begin
                addr_q <= i_wdata;
            end
            if (i_mask_wr) begin
                mask_q <= i_wdata;
            end
        end
    end

    // flags; frame error set wins over software write, but i_done_clear wins over a new done while ri_q is set
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            fe_q  <= 1'b0;
            m0_q  <= 1'b0;
            ri_q  <= 1'b0;
            rb8_q <= 1'b0;
            v_q   <= 1'b0;
            early_q <= 1'b0;
        end else begin
            v_q <= 1'b0;
            if (i_top_bit_wr && i_frame_check_enable) begin
                fe_q <= i_top_bit_wdata;
            end
            if (i_top_bit_wr && !i_frame_check_enable) begin
                m0_q <= i_top_bit_wdata;
            end
            if (i_serial_mode_bit_hi_wr) begin
                m0_q <= i_top_bit_wdata;
            end
            if (done_at_stop && chk_on && !stop_ok) begin
                fe_q <= 1'b1;
            end
            if (i_done_clear) begin
                ri_q <= 1'b0;
            end
            // stop bit lands after early done
            if (early_q && frame_end) begin
                rb8_q   <= stop_ok;
                early_q <= 1'b0;
            end
            if ((done_at_data || (frame_end && !(!chk_on && !nine_bit
                 && !mp_on))) && accept && !ri_q) begin
                ri_q  <= 1'b1;
                rb8_q <= rb8_in;
                v_q   <= 1'b1;
                early_q <= done_at_data;
            end
        end
    end

    assign rx_s.valid = v_q;
    assign rx_s.data  = sh_q;
    assign rx_s.ninth = rb8_in;

    ufc_buf2 u_buf (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .in_s    (rx_s),
        .o_valid (buf_valid),
        .o_data  (buf_data),
        .o_ninth (),
        .i_ready (!o_rx_valid)
    );

    // registered outputs
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rx_valid           <= 1'b0;
            o_rx_data            <= 8'h00;
            o_top_bit            <= 1'b0;
            o_frame_error_flag   <= 1'b0;
            o_receive_done_flag  <= 1'b0;
            o_received_ninth_bit <= 1'b0;
            o_own_address_reg    <= `UFC_ADDR_RST;
            o_address_mask_reg   <= `UFC_MASK_RST;
        end else begin
            if (buf_valid && !o_rx_valid) begin
                o_rx_valid <= 1'b1;
                o_rx_data  <= buf_data;
            end else if (i_rx_ready) begin
                o_rx_valid <= 1'b0;
            end
            o_top_bit            <= i_frame_check_enable ? fe_q : m0_q;
            o_frame_error_flag   <= fe_q;
            o_receive_done_flag  <= ri_q;
            o_received_ninth_bit <= rb8_q;
            o_own_address_reg    <= addr_q;
            o_address_mask_reg   <= mask_q;
        end
    end
endmodule

// file: tb/ufc_rx_props.sv
// port checker for the receive block
// assumes bind onto ufc_rx, one clock, synchronous reset
`timescale 1ns/1ps
module ufc_rx_props (
    // clock and reset
    input wire logic               i_mclk,
    input wire logic               i_rst,
    // controls
    input wire logic               i_frame_check_enable,
    input wire logic               i_top_bit_wr,
    input wire logic               i_done_clear,
    input wire logic               i_addr_wr,
    input wire logic               i_mask_wr,
    input wire ufc_pkg::ufc_byte_t i_wdata,
    input wire logic               i_rx_ready,
    // observed outputs
    input wire logic               o_top_bit,
    input wire logic               o_frame_error_flag,
    input wire logic               o_receive_done_flag,
    input wire ufc_pkg::ufc_byte_t o_own_address_reg,
    input wire ufc_pkg::ufc_byte_t o_address_mask_reg,
    input wire logic               o_rx_valid,
    input wire ufc_pkg::ufc_byte_t o_rx_data
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    chk_reset_clear:
    assert property ($past(i_rst) |-> !o_frame_error_flag &&
        !o_receive_done_flag && !o_rx_valid &&
        o_own_address_reg == 8'h00 && o_address_mask_reg == 8'h00)
        else $error("outputs not clear after reset");
    chk_addr_load:
    assert property (i_addr_wr |-> ##2
        o_own_address_reg == $past(i_wdata, 2))
        else $error("address register not loaded");
    chk_mask_load:
    assert property (i_mask_wr |-> ##2
        o_address_mask_reg == $past(i_wdata, 2))
        else $error("mask register not loaded");
    chk_err_sticky:
    assert property (o_frame_error_flag && !i_top_bit_wr &&
        !$past(i_top_bit_wr) |=> o_frame_error_flag)
        else $error("frame error flag dropped");
    chk_err_gated:
    assert property ($rose(o_frame_error_flag) |->
        $past(i_frame_check_enable, 2))
        else $error("frame error without check enable");
    chk_top_bit_mux:
    assert property ($past(i_frame_check_enable) &&
        $past(i_frame_check_enable, 2) && $past(i_frame_check_enable, 3)
        |-> o_top_bit == o_frame_error_flag)
        else $error("top bit does not show frame error");
    chk_done_sticky:
    assert property (o_receive_done_flag && !i_done_clear &&
        !$past(i_done_clear) |=> o_receive_done_flag)
        else $error("done flag dropped");
    chk_word_hold:
    assert property (o_rx_valid && !i_rx_ready |=>
        o_rx_valid && $stable(o_rx_data))
        else $error("word not held while stalled");
    chk_done_word:
    assert property ($rose(o_receive_done_flag) |-> ##[0:6] o_rx_valid)
        else $error("done without received word");
endmodule

bind ufc_rx ufc_rx_props ufc_rx_props_i (
    .i_mclk, .i_rst, .i_frame_check_enable, .i_top_bit_wr,
    .i_done_clear, .i_addr_wr, .i_mask_wr, .i_wdata, .i_rx_ready,
    .o_top_bit, .o_frame_error_flag, .o_receive_done_flag,
    .o_own_address_reg, .o_address_mask_reg, .o_rx_valid, .o_rx_data
);

// file: tb/ufc_line_model.sv
// far node on the serial line: baud source and frame sender
// assumes 16 ticks per bit, one tick every two clocks;
// bit length in clocks is set by the bench for the fixed-rate mode
`timescale 1ns/1ps
module ufc_line_model (
    input  wire logic i_mclk,
    output logic      o_rxd,
    output logic      o_baud_tick
);
    logic [1:0] div_q;
    int         bitlen = 32;
    initial begin
        o_rxd = 1'b1;
        o_baud_tick = 1'b0;
        div_q = 2'h0;
    end
    always @(negedge i_mclk) begin
        div_q <= div_q + 2'h1;
        o_baud_tick <= div_q[0];
    end
    task automatic put(input logic b);
        o_rxd = b;
        repeat (bitlen) @(negedge i_mclk);
    endtask
    // lsb first, optional ninth bit, stop level chosen by caller
    task automatic send(input logic [7:0] d, input logic [2:0] f);
        put(1'b0);
        for (int i = 0; i < 8; i++) put(d[i]);
        if (f[2]) put(f[1]);
        put(f[0]);
        o_rxd = 1'b1;
        repeat (16) @(negedge i_mclk);
    endtask
endmodule

// file: tb/ufc_rx_bench.sv
// self-checking bench for the receive block
// assumes line model on the serial pin, 25 MHz clock
`timescale 1ns/1ps
module ufc_rx_bench;
    logic               i_mclk, i_rst, i_rxd, i_baud_tick, i_fast_m2;
    logic               i_frame_check_enable, i_serial_mode_bit_hi_wr;
    logic               i_serial_mode_bit_lo, i_multiproc_enable;
    logic               i_receive_enable, i_top_bit_wr, i_top_bit_wdata;
    logic               i_done_clear, i_addr_wr, i_mask_wr, i_rx_ready;
    logic               o_top_bit, o_frame_error_flag, o_rx_valid;
    logic               o_receive_done_flag, o_received_ninth_bit;
    ufc_pkg::ufc_byte_t i_wdata, o_own_address_reg;
    ufc_pkg::ufc_byte_t o_address_mask_reg, o_rx_data;
    int                 error_cnt, comparisons;
    logic               stall;
    logic [23:0]        tbl [4] = '{24'h56ff56, 24'h56ff57,
                                    24'hf1faff, 24'hf1fafb};

    ufc_rx ufc_rx_i (
        .i_mclk, .i_rst, .i_rxd, .i_baud_tick, .i_fast_m2,
        .i_frame_check_enable, .i_serial_mode_bit_hi_wr,
        .i_serial_mode_bit_lo, .i_multiproc_enable, .i_receive_enable,
        .i_top_bit_wr, .i_top_bit_wdata, .i_done_clear, .i_addr_wr,
        .i_mask_wr, .i_wdata, .o_top_bit, .o_frame_error_flag,
        .o_receive_done_flag, .o_received_ninth_bit, .o_own_address_reg,
        .o_address_mask_reg, .o_rx_valid, .o_rx_data, .i_rx_ready
    );
    ufc_line_model ufc_line_model_i (
        .i_mclk, .o_rxd(i_rxd), .o_baud_tick(i_baud_tick)
    );

    task automatic close_out;
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic hit(input logic [7:0] a, m, r);
        return (((r ^ a) & m) == 8'h00) ||
               (((r ^ (a | m)) & (a | m)) == 8'h00);
    endfunction
    // f is mode high, mode low, multiproc, frame check
    task automatic setm(input logic [3:0] f);
        {i_top_bit_wdata, i_serial_mode_bit_lo} = f[3:2];
        {i_multiproc_enable, i_frame_check_enable} = f[1:0];
        i_serial_mode_bit_hi_wr = 1'b1;
        @(negedge i_mclk);
        i_serial_mode_bit_hi_wr = 1'b0;
        repeat (3) @(negedge i_mclk);
    endtask
    task automatic wra(input logic [7:0] a, m);
        i_addr_wr = 1'b1;
        i_wdata = a;
        @(negedge i_mclk);
        i_addr_wr = 1'b0;
        i_mask_wr = 1'b1;
        i_wdata = m;
        @(negedge i_mclk);
        i_mask_wr = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk8("addr", a, o_own_address_reg);
        chk8("mask", m, o_address_mask_reg);
    endtask
    task automatic pop(input logic [7:0] e);
        int k;
        k = 0;
        while (o_rx_valid !== 1'b1 && k < 40) begin
            @(negedge i_mclk);
            k++;
        end
        if (k == 40) begin
            error_cnt++;
            $display("CHECK FAILED valid exp 1 got 0");
            close_out;
        end
        chk8("data", e, o_rx_data);
        i_rx_ready = 1'b1;
        @(negedge i_mclk);
        i_rx_ready = 1'b0;
    endtask
    // f is use ninth, ninth, stop, done expected
    task automatic rx(input logic [7:0] d, input logic [3:0] f);
        ufc_line_model_i.send(d, f[3:1]);
        chk1("done", f[0], o_receive_done_flag);
        if (f[0]) begin
            chk1("ninth", f[3] ? f[2] : f[1], o_received_ninth_bit);
        end
        if (f[0] && !stall) pop(d);
        i_done_clear = 1'b1;
        @(negedge i_mclk);
        i_done_clear = 1'b0;
        repeat (3) @(negedge i_mclk);
        if (!f[0] && !stall) chk1("stray", 1'b0, o_rx_valid);
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        logic [7:0] a, m, r;
        {i_fast_m2, i_frame_check_enable, i_serial_mode_bit_hi_wr} = '0;
        {i_serial_mode_bit_lo, i_multiproc_enable, i_top_bit_wr} = '0;
        {i_top_bit_wdata, i_done_clear, i_addr_wr, i_mask_wr} = '0;
        {i_rx_ready, stall, i_wdata} = '0;
        {error_cnt, comparisons} = '0;
        i_receive_enable = 1'b1;
        i_rst = 1'b1;
        void'($urandom(15));
        repeat (12) @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        chk8("addr", 8'h00, o_own_address_reg);
        chk8("mask", 8'h00, o_address_mask_reg);
        setm(4'b1110);
        rx(8'($urandom), 4'b1111);
        setm(4'b0100);
        rx(8'h25, 4'b0011);
        fork
            rx(8'hbc, 4'b0001);
            begin
                repeat (296) @(negedge i_mclk);
                chk1("early", 1'b1, o_receive_done_flag);
            end
        join
        chk1("err", 1'b0, o_frame_error_flag);
        setm(4'b0101);
        fork
            rx(8'h5a, 4'b0001);
            begin
                repeat (296) @(negedge i_mclk);
                chk1("early", 1'b0, o_receive_done_flag);
            end
        join
        chk1("err", 1'b1, o_frame_error_flag);
        chk1("top", 1'b1, o_top_bit);
        rx(8'h0f, 4'b0011);
        chk1("err", 1'b1, o_frame_error_flag);
        i_top_bit_wr = 1'b1;
        i_top_bit_wdata = 1'b0;
        @(negedge i_mclk);
        i_top_bit_wr = 1'b0;
        repeat (3) @(negedge i_mclk);
        chk1("err", 1'b0, o_frame_error_flag);
        setm(4'b1100);
        chk1("top", 1'b1, o_top_bit);
        setm(4'b1110);
        for (int i = 0; i < 12; i++) begin
            {a, m, r} = {8'($urandom), 8'($urandom), 8'($urandom)};
            if (i < 4) {a, m, r} = tbl[i];
            else if (i[0]) r = a ^ (~m & r);
            wra(a, m);
            rx(r, {3'b111, hit(a, m, r)});
        end
        rx(a, 4'b1010);
        setm(4'b1100);
        wra(8'h56, 8'hff);
        rx(8'h57, 4'b1011);
        setm(4'b0110);
        rx(8'h56, 4'b0000);
        rx(8'h56, 4'b0011);
        rx(8'h57, 4'b0010);
        setm(4'b0010);
        rx(8'h56, 4'b0010);
        setm(4'b1000);
        for (int i = 0; i < 2; i++) begin
            i_fast_m2 = !i[0];
            ufc_line_model_i.bitlen = i[0] ? 1040 : 528;
            rx(8'hc3 ^ 8'(i), 4'b1011);
        end
        ufc_line_model_i.bitlen = 32;
        setm(4'b0100);
        stall = 1'b1;
        rx(8'h11, 4'b0011);
        rx(8'h22, 4'b0011);
        stall = 1'b0;
        pop(8'h11);
        pop(8'h22);
        repeat (4) @(negedge i_mclk);
        chk1("empty", 1'b0, o_rx_valid);
        setm(4'b0101);
        rx(8'h77, 4'b0001);
        chk1("err", 1'b1, o_frame_error_flag);
        wra(8'h12, 8'h34);
        i_rst = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        chk1("err", 1'b0, o_frame_error_flag);
        chk8("addr", 8'h00, o_own_address_reg);
        chk8("mask", 8'h00, o_address_mask_reg);
        close_out;
    end
endmodule
